// file: hw/ecpfs_top.sv
// fifo service, run-length expander, dma and interrupt logic of the parallel port
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
`include "ecpfs_consts.svh"
module ecpfs_top import ecpfs_pkg::*; #(
    parameter int         PULSE_CYC = `ECPFS_INTR_PULSE_CYC,
    parameter int         IDLE_CYC  = `ECPFS_ACK_IDLE_CYC,
    parameter logic [7:0] CFG_A     = 8'h10  // arbitrary value
) (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RESET,
    // register port
    input  wire logic [10:0] ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [7:0]  RDATA,
    // host dma pins
    input  wire logic        DMA_ACK_N,
    input  wire logic        DMA_TC,
    output logic             DMA_REQ,
    // shared interrupt pin
    output logic             INTR_O,
    output logic             INTR_OE,
    // peripheral status pins
    input  wire logic        FAULT_N,
    input  wire logic        ACK_N,
    // four control line drivers
    output logic      [3:0]  CTRL_O,
    output logic      [3:0]  CTRL_OE,
    // forward byte stream to the link engine
    output ecpfs_beat_t      TX_BEAT,
    output logic             TX_VALID,
    input  wire logic        TX_READY,
    // reverse byte stream from the link engine
    input  ecpfs_beat_t      RX_BEAT,
    input  wire logic        RX_VALID,
    output logic             RX_READY
);

    // modes in which the fifo is alive
    function automatic logic is_fifo_mode(input logic [2:0] m);
        is_fifo_mode = (m == `ECPFS_MODE_FIFO_OUT) || (m == `ECPFS_MODE_ECP) || (m == `ECPFS_MODE_TEST);
    endfunction
    // modes that move fifo bytes over the link
    function automatic logic is_link_mode(input logic [2:0] m);
        is_link_mode = (m == `ECPFS_MODE_FIFO_OUT) || (m == `ECPFS_MODE_ECP);
    endfunction
    // software state
    logic [2:0]  mode_ff;        // port mode
    logic        err_en_n_ff;    // error_intr_enable_n
    logic        dma_en_ff;      // dma_enable
    logic        mask_ff;        // service_intr_mask
    logic        dir_ff;         // 1 = reverse
    logic        ack_en_ff;      // ack_intr_enable
    logic [3:0]  ctl_ff;         // control line values
    logic [3:0]  thr_ff;         // threshold_field
    logic [7:0]  rdata_ff;       // read data, one cycle late
    // pin synchronisers: ack_n, tc, fault_n, peripheral ack_n
    logic [3:0]  sync1_ff;       // first stage, only read by second
    logic [3:0]  sync2_ff;       // safe copies
    logic [3:0]  prev_ff;        // delayed for edge detect
    logic        ack_act;        // dma acknowledge asserted
    logic        tc_rise;        // terminal count edge
    // fifo storage and pointers
    ecpfs_beat_t mem_ff [16];    // sixteen byte entries
    logic [3:0]  wptr_ff;
    logic [3:0]  rptr_ff;
    logic [4:0]  cnt_ff;         // bytes held
    logic [4:0]  free_cnt;       // bytes free
    logic        empty;
    logic        full;
    logic        fifo_en;
    logic        push;
    logic        pop;
    ecpfs_beat_t push_beat;
    // run-length expander
    ecpfs_rle_t  rle_ff;
    logic [6:0]  run_ff;         // pending run count
    logic [6:0]  left_ff;        // copies still to write
    logic [7:0]  rep_ff;         // byte being repeated
    logic        rx_take;
    logic        rle_push;
    // thresholds
    logic [4:0]  eff_thr;
    logic [4:0]  write_free_threshold;
    logic [4:0]  read_fill_threshold;
    // interrupt and dma state
    logic        svc_cond;
    logic        svc_prev_ff;
    logic        err_prev_ff;
    logic        tc_event;
    logic        fault_event;
    logic        ack_event;
    logic        any_event;
    logic [7:0]  pulse_ff;
    logic [5:0]  burst_ff;       // dma cycles in this burst
    logic        hold_ff;        // burst limit reached
    logic [15:0] idle_ff;        // cycles with ack inactive
    logic        dma_cyc;
    // register decode
    logic        rev_ecp;
    logic        wr_ecr;
    logic        host_wr_fifo;
    logic        host_rd_fifo;
    // synchroniser chain, all pins are asynchronous to CLK
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            sync1_ff <= 4'hD;
            sync2_ff <= 4'hD;
            prev_ff  <= 4'hD;
        end else begin
            sync1_ff <= {ACK_N, FAULT_N, DMA_TC, DMA_ACK_N};
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    // reset values match each pin's idle level, so no false edge after reset
    assign ack_act = ~sync2_ff[0];
    assign tc_rise = sync2_ff[1] & ~prev_ff[1];

    // threshold field plus one, sixteen treated as fifteen
    assign eff_thr = (thr_ff == 4'hF) ? `ECPFS_THR_MAX : ({1'b0, thr_ff} + 5'h01);
    assign write_free_threshold = `ECPFS_FIFO_DEPTH - eff_thr;
    assign read_fill_threshold  = `ECPFS_FIFO_DEPTH - eff_thr;

    // fifo only alive in fifo-output, extended and test modes
    assign fifo_en  = is_fifo_mode(mode_ff);
    assign empty    = (cnt_ff == 5'h00);
    assign full     = (cnt_ff == `ECPFS_FIFO_DEPTH);
    assign free_cnt = `ECPFS_FIFO_DEPTH - cnt_ff;
    assign rev_ecp  = (mode_ff == `ECPFS_MODE_ECP) & dir_ff;

    // dma cycles pick the fifo by acknowledge alone
    assign dma_cyc = ack_act & (WR | RD);

    // host writes: data at 400h, command at 000h
    assign host_wr_fifo = WR & (ack_act | (ADDR == `ECPFS_ADDR_DATA_FIFO)) & fifo_en
                        & ((mode_ff == `ECPFS_MODE_TEST) | ~dir_ff);
    assign host_rd_fifo = RD & (ack_act | (ADDR == `ECPFS_ADDR_DATA_FIFO))
                        & ((mode_ff == `ECPFS_MODE_TEST) | rev_ecp);

    // push source: expander in reverse extended mode, host otherwise
    always_comb begin
        push_beat = '0;
        push      = 1'b0;
        if (rev_ecp) begin
            push_beat.data = rle_push ? rep_ff : RX_BEAT.data;
            push           = rle_push | (rx_take & ~RX_BEAT.cmd);
        end else if (host_wr_fifo) begin
            push_beat.data = WDATA;
            push           = ~full;
        end else if (WR & ~ack_act & (ADDR == `ECPFS_ADDR_CMD_FIFO)
                     & (mode_ff == `ECPFS_MODE_ECP) & ~dir_ff) begin
            // command bytes queue beside data for the link
            push_beat.cmd  = 1'b1;
            push_beat.data = WDATA;
            push           = ~full;
        end
    end

    // link drains the fifo in modes 010 and 011 forward
    assign TX_VALID = is_link_mode(mode_ff) & ~dir_ff & ~empty;
    assign TX_BEAT  = mem_ff[rptr_ff];
    assign pop      = (TX_VALID & TX_READY) | (host_rd_fifo & ~empty);

    // fifo pointers and count, cleared whenever the fifo is disabled
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            wptr_ff <= 4'h0;
            rptr_ff <= 4'h0;
            cnt_ff  <= 5'h00;
        end else if (!fifo_en) begin
            wptr_ff <= 4'h0;
            rptr_ff <= 4'h0;
            cnt_ff  <= 5'h00;
        end else begin
            if (push) begin
                wptr_ff <= wptr_ff + 4'h1;
            end
            if (pop) begin
                rptr_ff <= rptr_ff + 4'h1;
            end
            if (push && !pop) begin
                cnt_ff <= cnt_ff + 5'h01;
            end else if (pop && !push) begin
                cnt_ff <= cnt_ff - 5'h01;
            end
        end
    end

    // storage array needs no reset, contents gated by count
    always_ff @(posedge CLK) begin
        if (push) begin
            mem_ff[wptr_ff] <= push_beat;
        end
    end

    // expander accepts bytes only when idle with room
    assign RX_READY = rev_ecp & (rle_ff == RLE_IDLE) & ~full;
    assign rx_take  = RX_READY & RX_VALID;
    assign rle_push = (rle_ff == RLE_REPEAT) & ~full;

    // run count n writes the next byte n+1 times
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rle_ff  <= RLE_IDLE;
            run_ff  <= 7'h00;
            left_ff <= 7'h00;
            rep_ff  <= 8'h00;
        end else if (!rev_ecp) begin
            rle_ff  <= RLE_IDLE;
            run_ff  <= 7'h00;
        end else begin
            unique case (rle_ff)
                RLE_IDLE: begin
                    if (rx_take && RX_BEAT.cmd) begin
                        // bit 7 set is a channel address, dropped here
                        if (!RX_BEAT.data[7]) begin
                            run_ff <= RX_BEAT.data[6:0];
                        end
                    end else if (rx_take) begin
                        // first copy goes in with the byte itself
                        rep_ff  <= RX_BEAT.data;
                        left_ff <= run_ff;
                        run_ff  <= 7'h00;
                        if (run_ff != 7'h00) begin
                            rle_ff <= RLE_REPEAT;
                        end
                    end
                end
                RLE_REPEAT: begin
                    // stalls while full, link held off by RX_READY
                    if (rle_push) begin
                        left_ff <= left_ff - 7'h01;
                        if (left_ff == 7'h01) begin
                            rle_ff <= RLE_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // extended control register write
    assign wr_ecr = WR & ~ack_act & (ADDR == `ECPFS_ADDR_EXT_CTRL);

    // mode and enables
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            mode_ff     <= `ECPFS_RST_MODE;
            err_en_n_ff <= `ECPFS_RST_ERR_EN_N;
            dma_en_ff   <= 1'b0;
        end else if (wr_ecr) begin
            mode_ff     <= WDATA[`ECPFS_ECR_MODE_HI:`ECPFS_ECR_MODE_LO];
            err_en_n_ff <= WDATA[`ECPFS_ECR_ERR_EN_N];
            dma_en_ff   <= WDATA[`ECPFS_ECR_DMA_EN];
        end
    end

    // terminal count sets the mask, winning over a clear
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            mask_ff <= `ECPFS_RST_MASK;
        end else if (tc_event) begin
            mask_ff <= 1'b1;
        end else if (wr_ecr) begin
            mask_ff <= WDATA[`ECPFS_ECR_MASK];
        end
    end

    // control register and threshold
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            dir_ff    <= 1'b0;
            ack_en_ff <= 1'b0;
            ctl_ff    <= 4'h0;
            thr_ff    <= 4'h0;
        end else if (WR && !ack_act) begin
            if (ADDR == `ECPFS_ADDR_CONTROL) begin
                dir_ff    <= WDATA[`ECPFS_CTL_DIR];
                ack_en_ff <= WDATA[`ECPFS_CTL_ACK_EN];
                ctl_ff    <= WDATA[3:0];
            end
            if (ADDR == `ECPFS_ADDR_THRESHOLD) begin
                thr_ff <= WDATA[3:0];
            end
        end
    end

    // open-collector in mode 000: drive only the low level
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_drv
            assign CTRL_O[gi]  = ctl_ff[gi];
            assign CTRL_OE[gi] = (mode_ff == `ECPFS_MODE_SPP) ? ~ctl_ff[gi] : 1'b1;
        end
    endgenerate

    // level condition for programmed i/o service
    assign svc_cond = ~mask_ff & ~dma_en_ff & fifo_en
                    & (dir_ff ? (cnt_ff >= read_fill_threshold) : (free_cnt >= write_free_threshold));

    // terminal count with acknowledge during enabled dma
    assign tc_event    = tc_rise & ack_act & dma_en_ff & ~mask_ff;
    // fault falling, or error_intr_enable_n cleared with fault low
    assign fault_event = ~err_en_n_ff & ((prev_ff[2] & ~sync2_ff[2]) | (err_prev_ff & ~sync2_ff[2]));
    assign ack_event   = ack_en_ff & ~prev_ff[3] & sync2_ff[3];
    // rising of the qualified condition covers mask release
    assign any_event   = (svc_cond & ~svc_prev_ff) | tc_event | fault_event | ack_event;

    // edge history for level conditions
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            svc_prev_ff <= 1'b0;
            err_prev_ff <= 1'b1;
        end else begin
            svc_prev_ff <= svc_cond;
            err_prev_ff <= err_en_n_ff;
        end
    end

    // low pulse lasting PULSE_CYC cycles after the latest event, then pin released for sharing
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            pulse_ff <= 8'h00;
        end else if (any_event) begin
            pulse_ff <= 8'(PULSE_CYC);
        end else if (pulse_ff != 8'h00) begin
            pulse_ff <= pulse_ff - 8'h01;
        end
    end

    assign INTR_O  = 1'b0;
    assign INTR_OE = (pulse_ff != 8'h00);

    // burst counter and idle timer on the acknowledge
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            burst_ff <= 6'h00;
            hold_ff  <= 1'b0;
            idle_ff  <= 16'h0000;
        end else begin
            if (ack_act) begin
                idle_ff <= 16'h0000;
            end else if (idle_ff != 16'(IDLE_CYC)) begin
                idle_ff <= idle_ff + 16'h0001;
            end
            if (!ack_act && idle_ff == 16'(IDLE_CYC)) begin
                // long enough idle restarts the burst
                burst_ff <= 6'h00;
                hold_ff  <= 1'b0;
            end else if (dma_cyc) begin
                burst_ff <= burst_ff + 6'h01;
                if (burst_ff + 6'h01 == `ECPFS_DMA_BURST_MAX) begin
                    hold_ff <= 1'b1;
                end
            end
        end
    end

    // request while serviceable, dropped at once on tc
    assign DMA_REQ = ~mask_ff & dma_en_ff & fifo_en & ~hold_ff & ~tc_event
                   & (dir_ff ? ~empty : ~full);

    // read data mux, registered so data stands the next cycle only
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rdata_ff <= 8'h00;
        end else if (RD) begin
            if (ack_act || ADDR == `ECPFS_ADDR_DATA_FIFO) begin
                if (!ack_act && mode_ff == `ECPFS_MODE_CONFIG) begin
                    rdata_ff <= CFG_A;
                end else begin
                    rdata_ff <= host_rd_fifo && !empty ? TX_BEAT.data : 8'h00;
                end
            end else begin
                unique case (ADDR)
                    `ECPFS_ADDR_STATUS:    rdata_ff <= {sync2_ff[3], sync2_ff[2], 1'b0, cnt_ff};
                    `ECPFS_ADDR_CONTROL:   rdata_ff <= {2'b00, dir_ff, ack_en_ff, ctl_ff};
                    `ECPFS_ADDR_EXT_CTRL:  rdata_ff <= {mode_ff, err_en_n_ff, dma_en_ff, mask_ff, full, empty};
                    `ECPFS_ADDR_THRESHOLD: rdata_ff <= {4'h0, thr_ff};
                    default:               rdata_ff <= 8'h00;
                endcase
            end
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign RDATA = rdata_ff;

endmodule

// file: pkg/ecpfs_consts.svh
// constants for the parallel port fifo service block
`ifndef ECPFS_CONSTS_SVH
`define ECPFS_CONSTS_SVH
// register offsets
`define ECPFS_ADDR_CMD_FIFO  11'h000
`define ECPFS_ADDR_STATUS    11'h001
`define ECPFS_ADDR_CONTROL   11'h002
`define ECPFS_ADDR_DATA_FIFO 11'h400
`define ECPFS_ADDR_CONFIG_B  11'h401
`define ECPFS_ADDR_EXT_CTRL  11'h402
`define ECPFS_ADDR_THRESHOLD 11'h403
// extended control fields
`define ECPFS_ECR_MODE_HI    7
`define ECPFS_ECR_MODE_LO    5
`define ECPFS_ECR_ERR_EN_N   4
`define ECPFS_ECR_DMA_EN     3
`define ECPFS_ECR_MASK       2
// control register fields
`define ECPFS_CTL_DIR        5
`define ECPFS_CTL_ACK_EN     4
// mode codes
`define ECPFS_MODE_SPP       3'h0
`define ECPFS_MODE_FIFO_OUT  3'h2
`define ECPFS_MODE_ECP       3'h3
`define ECPFS_MODE_TEST      3'h6
`define ECPFS_MODE_CONFIG    3'h7
// reset values
`define ECPFS_RST_MODE       3'h0
`define ECPFS_RST_MASK       1'b1
`define ECPFS_RST_ERR_EN_N   1'b1
// fifo and timing
`define ECPFS_FIFO_DEPTH     5'h10
`define ECPFS_THR_MAX        5'h0F
`define ECPFS_DMA_BURST_MAX  6'h20
`define ECPFS_CLK_NS         5
`define ECPFS_ACK_IDLE_NS    350
`define ECPFS_ACK_IDLE_CYC   ((`ECPFS_ACK_IDLE_NS + `ECPFS_CLK_NS - 1) / `ECPFS_CLK_NS)
`define ECPFS_INTR_PULSE_CYC 4
`endif

// file: pkg/ecpfs_pkg.sv
// types shared by the parallel port fifo service block
package ecpfs_pkg;
    // one fifo entry or link byte: command flag plus data
    typedef struct packed {
        logic       cmd;
        logic [7:0] data;
    } ecpfs_beat_t;
    // run-length expander states
    typedef enum logic {
        RLE_IDLE,
        RLE_REPEAT
    } ecpfs_rle_t;
endpackage

// file: dv/ecpfs_dma_host.sv
// host dma controller model: acks requests, writes bytes, ends on terminal count
`timescale 1ns/1ps
module ecpfs_dma_host (
    // clock and reset
    input  wire logic       CLK,
    input  wire logic       RESET,
    // bench control
    input  wire logic       start,
    input  wire logic [4:0] n_bytes,
    input  wire logic [3:0] gap,
    output logic            done,
    // dma pins
    input  wire logic       dma_req,
    output logic            ack_n,
    output logic            tc,
    output logic            wr,
    output logic      [7:0] wdata
);
    int i;
    // one byte per request, gap sets prompt or slow service
    initial begin
        ack_n = 1'b1;
        tc    = 1'b0;
        wr    = 1'b0;
        wdata = 8'h00;
        done  = 1'b0;
        forever begin
            @(posedge CLK);
            if (start && !RESET) begin
                for (i = 0; i < n_bytes; i++) begin
                    while (dma_req !== 1'b1) @(posedge CLK);
                    ack_n <= 1'b0;
                    // device needs two edges to see the ack
                    repeat (2) @(posedge CLK);
                    wr    <= 1'b1;
                    wdata <= 8'hC0 + i[7:0];
                    tc    <= (i == n_bytes - 1);
                    @(posedge CLK);
                    wr    <= 1'b0;
                    wdata <= ~(8'hC0 + i[7:0]);
                    repeat (3) @(posedge CLK);
                    tc    <= 1'b0;
                    ack_n <= 1'b1;
                    repeat (gap) @(posedge CLK);
                end
                done <= 1'b1;
            end
        end
    end
endmodule

// file: dv/ecpfs_top_props.sv
// port assertions for the fifo service block
`timescale 1ns/1ps
module ecpfs_top_chk import ecpfs_pkg::*; #(
    parameter int PULSE_CYC = 4
) (
    // clock and reset
    input wire logic       CLK,
    input wire logic       RESET,
    // register port
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    // dma pins
    input wire logic       DMA_ACK_N,
    input wire logic       DMA_TC,
    input wire logic       DMA_REQ,
    // interrupt and control drivers
    input wire logic       INTR_O,
    input wire logic       INTR_OE,
    input wire logic [3:0] CTRL_O,
    input wire logic [3:0] CTRL_OE,
    // link streams
    input wire logic       TX_VALID,
    input wire logic       RX_READY
);
    // length of the running interrupt pulse
    int unsigned run_ff;
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            run_ff <= 0;
        end else begin
            run_ff <= INTR_OE ? run_ff + 1 : 0;
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    chk_intr_low_only: assert property (INTR_O == 1'b0)
        else $error("interrupt pin driven high");
    chk_pulse_width: assert property ((!INTR_OE && run_ff != 0) |-> run_ff >= PULSE_CYC)
        else $error("interrupt pulse too short");
    chk_ctrl_drive: assert property (CTRL_OE == 4'hF || CTRL_OE == ~CTRL_O)
        else $error("control driver kind wrong");
    chk_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data outside read slot");
    chk_stream_dir: assert property (!(TX_VALID && RX_READY))
        else $error("both stream directions live");
    chk_tc_drops_req: assert property ((DMA_TC && !DMA_ACK_N) |-> ##[1:4] !DMA_REQ)
        else $error("request kept after terminal count");
    chk_tc_intr: assert property (($rose(DMA_TC) && !DMA_ACK_N && DMA_REQ) |-> ##[2:5] INTR_OE)
        else $error("no interrupt on terminal count");
    chk_reset_quiet: assert property ($fell(RESET) |-> !DMA_REQ && !INTR_OE && !TX_VALID)
        else $error("outputs active after reset");
endmodule

// file: dv/ecpfs_top_test.sv
// self-checking bench for the fifo service block
`timescale 1ns/1ps
module ecpfs_top_test import ecpfs_pkg::*; ;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [10:0] addr = 11'h000;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        fault_n = 1'b1;
    logic        ack_n = 1'b1;
    logic        tx_ready = 1'b0;
    ecpfs_beat_t rx_beat = 9'h000;
    logic        rx_valid = 1'b0;
    logic        h_start = 1'b0;
    logic [7:0]  rdata, h_wdata;
    logic [3:0]  ctrl_o, ctrl_oe;
    logic        dma_req, intr_oe, tx_valid, rx_ready, h_ack_n, h_tc, h_wr, h_done;
    ecpfs_beat_t tx_beat;
    int          n_fail = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          i;
    initial forever #2.5 clk = ~clk;
    ecpfs_top #(.CFG_A(8'h3C)) dut (.CLK(clk), .RESET(rst), .ADDR(addr), .WDATA(h_wr ? h_wdata : wdata),
        .WR(wr | h_wr), .RD(rd), .RDATA(rdata), .DMA_ACK_N(h_ack_n), .DMA_TC(h_tc),
        .DMA_REQ(dma_req), .INTR_O(), .INTR_OE(intr_oe), .FAULT_N(fault_n), .ACK_N(ack_n),
        .CTRL_O(ctrl_o), .CTRL_OE(ctrl_oe), .TX_BEAT(tx_beat), .TX_VALID(tx_valid),
        .TX_READY(tx_ready), .RX_BEAT(rx_beat), .RX_VALID(rx_valid), .RX_READY(rx_ready));
    ecpfs_dma_host host (.CLK(clk), .RESET(rst), .start(h_start), .n_bytes(5'h05), .gap(4'h3),
        .done(h_done), .dma_req(dma_req), .ack_n(h_ack_n), .tc(h_tc), .wr(h_wr), .wdata(h_wdata));
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [10:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic rd_reg(input logic [10:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 check({1'b0, rdata}, {1'b0, e});
    endtask
    // watch the interrupt pin for ten cycles
    task automatic wait_intr(input logic e);
        logic seen;
        seen = 1'b0;
        repeat (10) begin
            @(posedge clk);
            if (intr_oe === 1'b1) seen = 1'b1;
        end
        check(9'(seen), 9'(e));
    endtask
    // offer one link byte and hold it until taken
    task automatic send(input ecpfs_beat_t b);
        int k;
        @(posedge clk);
        rx_beat  <= b;
        rx_valid <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (rx_ready !== 1'b1 && k < 300);
        rx_valid <= 1'b0;
        rx_beat  <= ~b;
        if (k == 300) n_fail++;
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // hang guard, runs need well under this
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            complete_run();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        #1 check(9'(intr_oe), 9'h000);
        check(9'(ctrl_oe), 9'h00F);
        rd_reg(11'h402, 8'h15);
        rd_reg(11'h7FF, 8'h00);
        $display("test reset done");
        wr_reg(11'h002, 8'h05);
        #1 check(9'(ctrl_oe), 9'h00A);
        check(9'(ctrl_o), 9'h005);
        wr_reg(11'h403, 8'h03);
        wr_reg(11'h402, 8'h54);
        #1 check(9'(ctrl_oe), 9'h00F);
        wait_intr(1'b0);
        wr_reg(11'h402, 8'h50);
        wait_intr(1'b1);
        wr_reg(11'h402, 8'h14);
        wr_reg(11'h403, 8'h0F);
        wr_reg(11'h402, 8'h54);
        for (i = 0; i < 17; i++) wr_reg(11'h400, 8'(i));
        rd_reg(11'h001, 8'hD0);
        wr_reg(11'h402, 8'h50);
        wait_intr(1'b0);
        rd_reg(11'h402, 8'h52);
        @(posedge clk) tx_ready <= 1'b1;
        @(posedge clk) tx_ready <= 1'b0;
        wait_intr(1'b1);
        wr_reg(11'h402, 8'h14);
        $display("test forward pio done");
        wr_reg(11'h002, 8'h20);
        wr_reg(11'h402, 8'h74);
        send(9'h103);
        send(9'h0A5);
        send(9'h185);
        send(9'h011);
        send(9'h100);
        send(9'h022);
        repeat (4) @(posedge clk);
        rd_reg(11'h001, 8'hC6);
        wr_reg(11'h402, 8'h70);
        wait_intr(1'b1);
        repeat (4) rd_reg(11'h400, 8'hA5);
        rd_reg(11'h400, 8'h11);
        rd_reg(11'h400, 8'h22);
        rd_reg(11'h400, 8'h00);
        $display("test reverse expand done");
        wr_reg(11'h402, 8'h14);
        wr_reg(11'h002, 8'h00);
        wr_reg(11'h402, 8'h7C);
        wr_reg(11'h000, 8'h05);
        wr_reg(11'h402, 8'h78);
        repeat (3) @(posedge clk);
        check(9'(dma_req), 9'h001);
        @(posedge clk) h_start <= 1'b1;
        @(posedge clk) h_start <= 1'b0;
        while (h_done !== 1'b1) @(posedge clk);
        repeat (4) @(posedge clk);
        check(9'(dma_req), 9'h000);
        rd_reg(11'h402, 8'h7C);
        rd_reg(11'h001, 8'hC6);
        check(tx_beat, 9'h105);
        wr_reg(11'h402, 8'h74);
        @(posedge clk) tx_ready <= 1'b1;
        repeat (8) @(posedge clk);
        tx_ready <= 1'b0;
        rd_reg(11'h001, 8'hC0);
        $display("test dma done");
        wr_reg(11'h402, 8'h14);
        wr_reg(11'h002, 8'h10);
        @(posedge clk) ack_n <= 1'b0;
        repeat (4) @(posedge clk);
        ack_n <= 1'b1;
        wait_intr(1'b1);
        @(posedge clk) fault_n <= 1'b0;
        wait_intr(1'b0);
        wr_reg(11'h402, 8'h04);
        wait_intr(1'b1);
        $display("test pin events done");
        wr_reg(11'h402, 8'hD4);
        wr_reg(11'h400, 8'h5A);
        #1 check(9'(tx_valid), 9'h000);
        rd_reg(11'h400, 8'h5A);
        wr_reg(11'h402, 8'h14);
        wr_reg(11'h402, 8'hF4);
        rd_reg(11'h400, 8'h3C);
        $display("test fifo modes done");
        complete_run();
    end
endmodule
bind ecpfs_top ecpfs_top_chk #(.PULSE_CYC(PULSE_CYC)) u_chk (.CLK(CLK), .RESET(RESET), .RD(RD),
    .RDATA(RDATA), .DMA_ACK_N(DMA_ACK_N), .DMA_TC(DMA_TC), .DMA_REQ(DMA_REQ), .INTR_O(INTR_O),
    .INTR_OE(INTR_OE), .CTRL_O(CTRL_O), .CTRL_OE(CTRL_OE), .TX_VALID(TX_VALID), .RX_READY(RX_READY));
